/* File: txb_pkg.sv */
// Shared constants and types for the transmit system bus input stage
// How it works
// - Transmit system clock times every bus signal
// - 8-bit address selects port or polls status
// - Packet level-3 address is 5-bit poll only
// - Address bit 7 is MSB, sampled each edge
// - 32-bit data bus captured on every edge
// - 32-bit width: bit 31 MSB, bit 0 LSB
// - 16-bit width uses 15:0, ignores upper bits
// - 8-bit width uses 7:0, ignores upper bits
// - Word taken only while transfer enable low
// - Parity checked when enabled, ignored otherwise
// - Polled space output follows addressed port threshold, held low while FIFO full
package txb_pkg;

   typedef enum logic [1:0] {
      TXB_UTOPIA_L2,
      TXB_UTOPIA_L3,
      TXB_PACKET_L2,
      TXB_PACKET_L3
   } txb_mode_t;

   typedef enum logic [1:0] {
      TXB_W8,
      TXB_W16,
      TXB_W32
   } txb_width_t;

   localparam int ADDR_W        = 8;
   localparam int PKT_L3_ADDR_W = 5;
   localparam int DATA_W        = 32;
   localparam int NPORTS        = 12;
   localparam int CELL_CNT_W    = 8;
   localparam int FIFO_DEPTH    = 8;
   localparam int CFG_W         = 6;

   // Field positions of the configuration word carried across clocks
   localparam int CFG_MODE_LSB  = 0;
   localparam int CFG_WIDTH_LSB = 2;
   localparam int CFG_PAR_EN    = 4;
   localparam int CFG_PAR_ODD   = 5;

   // Link clock ceilings, kept by the far side, and the core clock rate
   localparam int TX_SYS_CLOCK_MAX_L3_MHZ = 104;
   localparam int TX_SYS_CLOCK_MAX_L2_MHZ = 52;
   localparam int MCLK_MHZ         = 125;

   localparam logic [CFG_W-1:0] CFG_RESET = 6'h00;

endpackage : txb_pkg

/* File: txb_fifo.sv */
// Dual-clock word FIFO with gray pointers and a two-flop synchroniser
`timescale 1ns/1ps

module txb_sync2 #(
   parameter int W = 1
) (
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] meta_r;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_r <= '0;
         q      <= '0;
      end else begin
         meta_r <= d;
         q      <= meta_r;
      end
   end
endmodule : txb_sync2

module txb_fifo #(
   parameter int WIDTH = 37,
   parameter int DEPTH = 8
) (
   input  wire logic             wclk,
   input  wire logic             wrst_n,
   input  wire logic             w_valid,
   output logic                  w_ready,
   input  wire logic [WIDTH-1:0] w_data,
   input  wire logic             rclk,
   input  wire logic             rrst_n,
   output logic                  r_valid,
   input  wire logic             r_ready,
   output logic      [WIDTH-1:0] r_data
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0]      wbin_r;
   logic [AW:0]      wgray_r;
   logic [AW:0]      rbin_r;
   logic [AW:0]      rgray_r;
   logic [AW:0]      rgray_w;
   logic [AW:0]      wgray_rd;

   function automatic logic [AW:0] to_gray(input logic [AW:0] b);
      to_gray = b ^ (b >> 1);
   endfunction : to_gray

   txb_sync2 #(.W(AW+1)) u_rp (.clk(wclk), .rst_n(wrst_n), .d(rgray_r), .q(rgray_w));
   txb_sync2 #(.W(AW+1)) u_wp (.clk(rclk), .rst_n(rrst_n), .d(wgray_r), .q(wgray_rd));

   // Full compares against a stale read pointer, so it can only err towards full
   assign w_ready = (wgray_r != {~rgray_w[AW:AW-1], rgray_w[AW-2:0]});
   assign r_valid = (rgray_r != wgray_rd);
   assign r_data  = mem[rbin_r[AW-1:0]];

   always_ff @(posedge wclk) begin
      if (w_valid && w_ready) begin
         mem[wbin_r[AW-1:0]] <= w_data;
      end
   end

   always_ff @(posedge wclk or negedge wrst_n) begin
      if (!wrst_n) begin
         wbin_r  <= '0;
         wgray_r <= '0;
      end else if (w_valid && w_ready) begin
         wbin_r  <= wbin_r + 1'b1;
         wgray_r <= to_gray(wbin_r + 1'b1);
      end
   end

   always_ff @(posedge rclk or negedge rrst_n) begin
      if (!rrst_n) begin
         rbin_r  <= '0;
         rgray_r <= '0;
      end else if (r_valid && r_ready) begin
         rbin_r  <= rbin_r + 1'b1;
         rgray_r <= to_gray(rbin_r + 1'b1);
      end
   end
endmodule : txb_fifo

/* File: txb_tx_bus_input.sv */
// Transmit system bus input stage: link capture, port polling, word FIFO to core
`timescale 1ns/1ps

module txb_tx_bus_input #(
   parameter int NPORTS     = txb_pkg::NPORTS,
   parameter int FIFO_DEPTH = txb_pkg::FIFO_DEPTH
) (
   input  wire logic                                         mclk,
   input  wire logic                                         nrst,
   input  wire logic                                         tx_sys_clock,
   input  wire logic [txb_pkg::ADDR_W-1:0]                   tx_port_address,
   input  wire logic [txb_pkg::DATA_W-1:0]                   tx_data,
   input  wire logic                                         tx_transfer_enable_n,
   input  wire logic                                         tx_bus_parity,
   output logic                                              tx_polled_space_available,
   output logic                                              tx_polled_space_available_oe_n,
   input  wire txb_pkg::txb_mode_t                           cfg_bus_mode,
   input  wire txb_pkg::txb_width_t                          cfg_bus_width,
   input  wire logic                                         cfg_parity_en,
   input  wire logic                                         cfg_parity_odd,
   input  wire logic [txb_pkg::CELL_CNT_W-1:0]               cfg_cell_threshold,
   input  wire logic [NPORTS*txb_pkg::CELL_CNT_W-1:0]        port_cells_free,
   output logic                                              word_valid,
   input  wire logic                                         word_ready,
   output logic      [txb_pkg::DATA_W-1:0]                   word_data,
   output logic      [$clog2(NPORTS)-1:0]                    word_port,
   output logic                                              word_parity_err,
   output logic                                              overflow_seen
);
   localparam int PORT_W = $clog2(NPORTS);
   localparam int PW     = txb_pkg::DATA_W + PORT_W + 1;
   localparam int CW     = txb_pkg::CELL_CNT_W;

   // ---------------- Helper functions ----------------
   function automatic logic [txb_pkg::DATA_W-1:0] lane_mask(
      input logic [txb_pkg::DATA_W-1:0] d,
      input txb_pkg::txb_width_t        w);
      unique case (w)
         txb_pkg::TXB_W8:  lane_mask = {24'h000000, d[7:0]};
         txb_pkg::TXB_W16: lane_mask = {16'h0000, d[15:0]};
         default:          lane_mask = d;
      endcase
   endfunction : lane_mask

   function automatic logic [txb_pkg::ADDR_W-1:0] poll_index(
      input logic [txb_pkg::ADDR_W-1:0] a,
      input txb_pkg::txb_mode_t         m);
      if (m == txb_pkg::TXB_PACKET_L3) begin
         poll_index = {3'h0, a[txb_pkg::PKT_L3_ADDR_W-1:0]};
      end else begin
         poll_index = a;
      end
   endfunction : poll_index

   function automatic logic is_port(input logic [txb_pkg::ADDR_W-1:0] a);
      is_port = (a < txb_pkg::ADDR_W'(NPORTS));
   endfunction : is_port

   // ---------------- Link-domain reset ----------------
   // Asserts with nrst, releases on the link clock so no link flop sees a runt release
   logic l_rst_meta_r;
   logic l_rst_n_r;

   always_ff @(posedge tx_sys_clock or negedge nrst) begin
      if (!nrst) begin
         l_rst_meta_r <= 1'b0;
         l_rst_n_r    <= 1'b0;
      end else begin
         l_rst_meta_r <= 1'b1;
         l_rst_n_r    <= l_rst_meta_r;
      end
   end

   // ---------------- Configuration into link domain ----------------
   logic [txb_pkg::CFG_W-1:0] cfg_m_r;
   logic [txb_pkg::CFG_W-1:0] cfg_l;
   txb_pkg::txb_mode_t        mode_l;
   txb_pkg::txb_width_t       width_l;
   logic                      par_en_l;
   logic                      par_odd_l;

   // Static settings: a change mid-traffic lands on a word boundary only by luck
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         cfg_m_r <= txb_pkg::CFG_RESET;
      end else begin
         cfg_m_r <= {cfg_parity_odd, cfg_parity_en, cfg_bus_width, cfg_bus_mode};
      end
   end

   txb_sync2 #(.W(txb_pkg::CFG_W)) u_cfg_sync (
      .clk   (tx_sys_clock),
      .rst_n (l_rst_n_r),
      .d     (cfg_m_r),
      .q     (cfg_l)
   );

   assign mode_l    = txb_pkg::txb_mode_t'(cfg_l[txb_pkg::CFG_MODE_LSB +: 2]);
   assign width_l   = txb_pkg::txb_width_t'(cfg_l[txb_pkg::CFG_WIDTH_LSB +: 2]);
   assign par_en_l  = cfg_l[txb_pkg::CFG_PAR_EN];
   assign par_odd_l = cfg_l[txb_pkg::CFG_PAR_ODD];

   // ---------------- Per-port space, judged in core domain ----------------
   logic [2**PORT_W-1:0] space_m_r;
   logic [2**PORT_W-1:0] space_l;

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         space_m_r <= '0;
      end else begin
         for (int p = 0; p < 2**PORT_W; p++) begin
            if (p < NPORTS) begin
               space_m_r[p] <= (port_cells_free[p*CW +: CW] > cfg_cell_threshold);
            end else begin
               space_m_r[p] <= 1'b0;
            end
         end
      end
   end

   txb_sync2 #(.W(2**PORT_W)) u_space_sync (
      .clk   (tx_sys_clock),
      .rst_n (l_rst_n_r),
      .d     (space_m_r),
      .q     (space_l)
   );

   // ---------------- Link capture ----------------
   logic [txb_pkg::ADDR_W-1:0] a_r;
   logic [txb_pkg::DATA_W-1:0] d_r;
   logic                       en_n_r;
   logic                       par_r;

   // All bus inputs sampled on the same rising edge of the link clock
   always_ff @(posedge tx_sys_clock or negedge l_rst_n_r) begin
      if (!l_rst_n_r) begin
         a_r    <= '0;
         d_r    <= '0;
         en_n_r <= 1'b1;
         par_r  <= 1'b0;
      end else begin
         a_r    <= tx_port_address;
         d_r    <= tx_data;
         en_n_r <= tx_transfer_enable_n;
         par_r  <= tx_bus_parity;
      end
   end

   // ---------------- Port selection ----------------
   logic [PORT_W-1:0] sel_port_r;

   always_ff @(posedge tx_sys_clock or negedge l_rst_n_r) begin
      if (!l_rst_n_r) begin
         sel_port_r <= '0;
      end else if (en_n_r && mode_l != txb_pkg::TXB_PACKET_L3 && is_port(a_r)) begin
         sel_port_r <= a_r[PORT_W-1:0];
      end
      // Packet level-3 addresses only poll; selection is left untouched
   end

   // ---------------- Word assembly ----------------
   logic                       w_valid_r;
   logic [txb_pkg::DATA_W-1:0] w_data_r;
   logic [PORT_W-1:0]          w_port_r;
   logic                       w_perr_r;
   logic                       fifo_w_ready;

   always_ff @(posedge tx_sys_clock or negedge l_rst_n_r) begin
      if (!l_rst_n_r) begin
         w_valid_r <= 1'b0;
         w_data_r  <= '0;
         w_port_r  <= '0;
         w_perr_r  <= 1'b0;
      end else begin
         w_valid_r <= !en_n_r;
         w_data_r  <= lane_mask(d_r, width_l);
         w_port_r  <= sel_port_r;
         // Parity covers only the lanes in use
         w_perr_r  <= par_en_l && (^lane_mask(d_r, width_l) ^ par_r ^ par_odd_l);
      end
   end

   // ---------------- Polled space output ----------------
   logic [txb_pkg::ADDR_W-1:0] poll_a;
   logic                       poll_hit;

   assign poll_a   = poll_index(a_r, mode_l);
   assign poll_hit = is_port(poll_a);

   // A full FIFO withdraws space so the far side backs off instead of losing words
   always_ff @(posedge tx_sys_clock or negedge l_rst_n_r) begin
      if (!l_rst_n_r) begin
         tx_polled_space_available      <= 1'b0;
         tx_polled_space_available_oe_n <= 1'b1;
      end else begin
         tx_polled_space_available <= poll_hit && space_l[poll_a[PORT_W-1:0]] && fifo_w_ready;
         if (mode_l == txb_pkg::TXB_UTOPIA_L3 || mode_l == txb_pkg::TXB_PACKET_L3) begin
            tx_polled_space_available_oe_n <= 1'b0;
         end else begin
            tx_polled_space_available_oe_n <= !poll_hit;
         end
      end
   end

   // ---------------- Overflow report ----------------
   logic ovf_tgl_r;
   logic ovf_tgl_m;
   logic ovf_tgl_d_r;

   always_ff @(posedge tx_sys_clock or negedge l_rst_n_r) begin
      if (!l_rst_n_r) begin
         ovf_tgl_r <= 1'b0;
      end else if (w_valid_r && !fifo_w_ready) begin
         ovf_tgl_r <= !ovf_tgl_r;
      end
   end

   txb_sync2 #(.W(1)) u_ovf_sync (
      .clk   (mclk),
      .rst_n (nrst),
      .d     (ovf_tgl_r),
      .q     (ovf_tgl_m)
   );

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         ovf_tgl_d_r   <= 1'b0;
         overflow_seen <= 1'b0;
      end else begin
         ovf_tgl_d_r <= ovf_tgl_m;
         if (ovf_tgl_m != ovf_tgl_d_r) begin
            overflow_seen <= 1'b1;
         end
      end
   end

   // ---------------- Crossing FIFO ----------------
   logic          fifo_r_valid;
   logic          fifo_r_ready;
   logic [PW-1:0] fifo_r_data;

   txb_fifo #(.WIDTH(PW), .DEPTH(FIFO_DEPTH)) u_fifo (
      .wclk    (tx_sys_clock),
      .wrst_n  (l_rst_n_r),
      .w_valid (w_valid_r),
      .w_ready (fifo_w_ready),
      .w_data  ({w_perr_r, w_port_r, w_data_r}),
      .rclk    (mclk),
      .rrst_n  (nrst),
      .r_valid (fifo_r_valid),
      .r_ready (fifo_r_ready),
      .r_data  (fifo_r_data)
   );

   // ---------------- Core-side output register ----------------
   assign fifo_r_ready = !word_valid || word_ready;

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         word_valid      <= 1'b0;
         word_data       <= '0;
         word_port       <= '0;
         word_parity_err <= 1'b0;
      end else if (fifo_r_ready) begin
         word_valid <= fifo_r_valid;
         if (fifo_r_valid) begin
            word_data       <= fifo_r_data[txb_pkg::DATA_W-1:0];
            word_port       <= fifo_r_data[txb_pkg::DATA_W +: PORT_W];
            word_parity_err <= fifo_r_data[PW-1];
         end
      end
   end

   // ---------------- Assertions ----------------
   sequence s_enable_low;
      !en_n_r;
   endsequence

   sequence s_select_cycle;
      en_n_r && mode_l != txb_pkg::TXB_PACKET_L3 && is_port(a_r);
   endsequence

   sequence s_poll_ready;
      poll_hit && space_l[poll_a[PORT_W-1:0]] && fifo_w_ready;
   endsequence

   a_addr_capture: assert property (
      @(posedge tx_sys_clock) disable iff (!l_rst_n_r)
      ##1 a_r == $past(tx_port_address))
      else $error("address not captured on link edge");

   a_data_capture: assert property (
      @(posedge tx_sys_clock) disable iff (!l_rst_n_r)
      ##1 d_r == $past(tx_data))
      else $error("data not captured on link edge");

   a_xfer_on_low: assert property (
      @(posedge tx_sys_clock) disable iff (!l_rst_n_r)
      s_enable_low |=> w_valid_r)
      else $error("enabled word not forwarded");

   a_no_xfer_high: assert property (
      @(posedge tx_sys_clock) disable iff (!l_rst_n_r)
      en_n_r |=> !w_valid_r)
      else $error("word forwarded with enable high");

   a_width32_keep: assert property (
      @(posedge tx_sys_clock) disable iff (!l_rst_n_r)
      width_l == txb_pkg::TXB_W32 && $stable(width_l) |=> w_data_r == $past(d_r))
      else $error("32-bit word altered");

   a_width16_mask: assert property (
      @(posedge tx_sys_clock) disable iff (!l_rst_n_r)
      width_l == txb_pkg::TXB_W16 |=> w_data_r == {16'h0000, $past(d_r[15:0])})
      else $error("16-bit lanes wrong");

   a_width8_mask: assert property (
      @(posedge tx_sys_clock) disable iff (!l_rst_n_r)
      width_l == txb_pkg::TXB_W8 |=> w_data_r == {24'h000000, $past(d_r[7:0])})
      else $error("8-bit lanes wrong");

   a_parity_off: assert property (
      @(posedge tx_sys_clock) disable iff (!l_rst_n_r)
      !par_en_l ##1 !par_en_l |-> !w_perr_r)
      else $error("parity error while checking disabled");

   a_port_select: assert property (
      @(posedge tx_sys_clock) disable iff (!l_rst_n_r)
      s_select_cycle |=> sel_port_r == $past(a_r[PORT_W-1:0]))
      else $error("port not selected from address");

   a_pkt3_no_select: assert property (
      @(posedge tx_sys_clock) disable iff (!l_rst_n_r)
      mode_l == txb_pkg::TXB_PACKET_L3 && $past(mode_l) == txb_pkg::TXB_PACKET_L3
      |-> $stable(sel_port_r))
      else $error("packet level-3 address changed selection");

   a_poll_value: assert property (
      @(posedge tx_sys_clock) disable iff (!l_rst_n_r)
      s_poll_ready |=> tx_polled_space_available)
      else $error("space not reported for polled port");

   a_l3_driven: assert property (
      @(posedge tx_sys_clock) disable iff (!l_rst_n_r)
      (mode_l == txb_pkg::TXB_UTOPIA_L3 || mode_l == txb_pkg::TXB_PACKET_L3) |=> !tx_polled_space_available_oe_n)
      else $error("level-3 space output not driven");

   a_out_hold: assert property (
      @(posedge mclk) disable iff (!nrst)
      word_valid && !word_ready |=> word_valid && $stable(word_data) && $stable(word_port))
      else $error("stalled word changed");

endmodule : txb_tx_bus_input

/* File: txb_link_model.sv */
// Link-side controller model driving the transmit system bus on its own clock
`timescale 1ns/1ps

module txb_link_model (
   output logic        tx_sys_clock,
   output logic [7:0]  tx_port_address,
   output logic [31:0] tx_data,
   output logic        tx_transfer_enable_n,
   output logic        tx_bus_parity,
   input  wire logic   space_wire
);

   // 80 ns period stays well under both ceilings
   initial tx_sys_clock = 1'b0;
   always #40 tx_sys_clock = ~tx_sys_clock;

   initial begin
      tx_port_address      = 8'h00;
      tx_data              = 32'h0000_0000;
      tx_transfer_enable_n = 1'b1;
      tx_bus_parity        = 1'b0;
   end

   // Every pin changes only at a link rising edge
   task automatic idle(input int n);
      repeat (n) @(posedge tx_sys_clock);
   endtask : idle

   // Select cycle with enable high, then n words back to back
   task automatic send(input logic [7:0] port, input logic [31:0] d, input logic p, input int n);
      @(posedge tx_sys_clock);
      tx_port_address      <= port;
      tx_transfer_enable_n <= 1'b1;
      tx_data              <= ~tx_data;
      for (int i = 0; i < n; i++) begin
         @(posedge tx_sys_clock);
         tx_transfer_enable_n <= 1'b0;
         tx_data              <= d + i;
         tx_bus_parity        <= p;
      end
      // Released lanes show the inverse so a stale capture cannot pass
      @(posedge tx_sys_clock);
      tx_transfer_enable_n <= 1'b1;
      tx_data              <= ~(d + n - 1);
      tx_bus_parity        <= ~p;
   endtask : send

   // Address held; reply read two link edges after the sampling edge
   task automatic poll(input logic [7:0] a, output logic v);
      @(posedge tx_sys_clock);
      tx_port_address      <= a;
      tx_transfer_enable_n <= 1'b1;
      repeat (3) @(posedge tx_sys_clock);
      #1;
      v = space_wire;
   endtask : poll

endmodule : txb_link_model

/* File: tb.sv */
// Self-checking testbench for the transmit system bus input stage
`timescale 1ns/1ps

module tb;

   logic                   mclk;
   logic                   nrst;
   wire logic              tx_sys_clock;
   wire logic [7:0]        tx_port_address;
   wire logic [31:0]       tx_data;
   wire logic              tx_transfer_enable_n;
   wire logic              tx_bus_parity;
   logic                   tx_polled_space_available;
   logic                   tx_polled_space_available_oe_n;
   wire logic              space_wire;
   txb_pkg::txb_mode_t     cfg_bus_mode;
   txb_pkg::txb_width_t    cfg_bus_width;
   logic                   cfg_parity_en;
   logic                   cfg_parity_odd;
   logic [7:0]             cfg_cell_threshold;
   logic [95:0]            port_cells_free;
   logic                   word_valid;
   logic                   word_ready;
   logic [31:0]            word_data;
   logic [3:0]             word_port;
   logic                   word_parity_err;
   logic                   overflow_seen;
   int                     compares;
   int                     miscompares;

   // Pin has no pull, so an undriven wire floats
   assign space_wire = tx_polled_space_available_oe_n ? 1'bz : tx_polled_space_available;

   always #4 mclk = ~mclk;

   txb_tx_bus_input i_txb_tx_bus_input (
      .mclk                           (mclk),
      .nrst                           (nrst),
      .tx_sys_clock                   (tx_sys_clock),
      .tx_port_address                (tx_port_address),
      .tx_data                        (tx_data),
      .tx_transfer_enable_n           (tx_transfer_enable_n),
      .tx_bus_parity                  (tx_bus_parity),
      .tx_polled_space_available      (tx_polled_space_available),
      .tx_polled_space_available_oe_n (tx_polled_space_available_oe_n),
      .cfg_bus_mode                   (cfg_bus_mode),
      .cfg_bus_width                  (cfg_bus_width),
      .cfg_parity_en                  (cfg_parity_en),
      .cfg_parity_odd                 (cfg_parity_odd),
      .cfg_cell_threshold             (cfg_cell_threshold),
      .port_cells_free                (port_cells_free),
      .word_valid                     (word_valid),
      .word_ready                     (word_ready),
      .word_data                      (word_data),
      .word_port                      (word_port),
      .word_parity_err                (word_parity_err),
      .overflow_seen                  (overflow_seen)
   );

   txb_link_model i_txb_link_model (
      .tx_sys_clock         (tx_sys_clock),
      .tx_port_address      (tx_port_address),
      .tx_data              (tx_data),
      .tx_transfer_enable_n (tx_transfer_enable_n),
      .tx_bus_parity        (tx_bus_parity),
      .space_wire           (space_wire)
   );

   task automatic finish_test;
      $display("compares=%0d miscompares=%0d", compares, miscompares);
      if (miscompares == 0 && compares > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : finish_test

   task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
      compares++;
      if (got !== exp) begin
         miscompares++;
         $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask : check

   function automatic logic [31:0] masked(input logic [31:0] d, input txb_pkg::txb_width_t w);
      case (w)
         txb_pkg::TXB_W8:  masked = {24'h000000, d[7:0]};
         txb_pkg::TXB_W16: masked = {16'h0000, d[15:0]};
         default:          masked = d;
      endcase
   endfunction : masked

   task automatic set_cfg(input txb_pkg::txb_mode_t m, input txb_pkg::txb_width_t w, input logic pe,
                          input logic po);
      @(posedge mclk);
      cfg_bus_mode   <= m;
      cfg_bus_width  <= w;
      cfg_parity_en  <= pe;
      cfg_parity_odd <= po;
      i_txb_link_model.idle(4);
   endtask : set_cfg

   // Bounded wait for a word, compare it, then accept it for one edge
   task automatic get_word(input logic [31:0] d, input logic [3:0] p, input logic e);
      int n;
      n = 0;
      do begin
         @(posedge mclk);
         n++;
      end while (word_valid !== 1'b1 && n < 300);
      if (n >= 300) begin
         miscompares++;
         $display("CHECK FAILED at %0t: no word arrived", $time);
         finish_test();
      end
      check(word_data, d, "word data");
      check(word_port, p, "word port");
      check(word_parity_err, e, "parity flag");
      word_ready <= 1'b1;
      @(posedge mclk);
      word_ready <= 1'b0;
   endtask : get_word

   task automatic poll_chk(input logic [7:0] a, input logic exp);
      logic v;
      i_txb_link_model.poll(a, v);
      check(v, exp, "polled space");
   endtask : poll_chk

   task automatic t_width;
      txb_pkg::txb_width_t w;
      for (int i = 0; i < 3; i++) begin
         w = txb_pkg::txb_width_t'(i);
         set_cfg(txb_pkg::TXB_UTOPIA_L2, w, 1'b0, 1'b0);
         i_txb_link_model.send(8'h05, 32'hA5C3_96E1, 1'b0, 2);
         get_word(masked(32'hA5C3_96E1, w), 4'h5, 1'b0);
         get_word(masked(32'hA5C3_96E2, w), 4'h5, 1'b0);
      end
   endtask : t_width

   task automatic par_case(input txb_pkg::txb_width_t w, input logic pe, input logic po,
                           input logic [31:0] d, input logic p, input logic e);
      set_cfg(txb_pkg::TXB_UTOPIA_L2, w, pe, po);
      i_txb_link_model.send(8'h02, d, p, 1);
      get_word(masked(d, w), 4'h2, e);
   endtask : par_case

   task automatic t_parity;
      par_case(txb_pkg::TXB_W32, 1'b1, 1'b0, 32'h0000_0001, 1'b1, 1'b0);
      par_case(txb_pkg::TXB_W32, 1'b1, 1'b0, 32'h0000_0001, 1'b0, 1'b1);
      par_case(txb_pkg::TXB_W32, 1'b1, 1'b1, 32'h0000_0001, 1'b0, 1'b0);
      par_case(txb_pkg::TXB_W8, 1'b1, 1'b0, 32'h7F00_0003, 1'b0, 1'b0);
      par_case(txb_pkg::TXB_W32, 1'b0, 1'b0, 32'h0000_0001, 1'b0, 1'b0);
   endtask : t_parity

   task automatic t_poll;
      set_cfg(txb_pkg::TXB_UTOPIA_L2, txb_pkg::TXB_W32, 1'b0, 1'b0);
      @(posedge mclk);
      port_cells_free[3*8+:8] <= 8'h0A;
      cfg_cell_threshold      <= 8'h05;
      i_txb_link_model.idle(4);
      poll_chk(8'h03, 1'b1);
      poll_chk(8'h83, 1'bz);
      check(tx_polled_space_available_oe_n, 1'b1, "space pin released");
      poll_chk(8'h0B, 1'b1);
      @(posedge mclk);
      cfg_cell_threshold <= 8'h0A;
      i_txb_link_model.idle(4);
      poll_chk(8'h03, 1'b0);
      set_cfg(txb_pkg::TXB_UTOPIA_L3, txb_pkg::TXB_W32, 1'b0, 1'b0);
      poll_chk(8'h0C, 1'b0);
      check(word_valid, 1'b0, "no transfer while enable high");
   endtask : t_poll

   task automatic t_pkt_l3;
      @(posedge mclk);
      cfg_cell_threshold <= 8'h05;
      set_cfg(txb_pkg::TXB_PACKET_L2, txb_pkg::TXB_W16, 1'b0, 1'b0);
      i_txb_link_model.send(8'h04, 32'h5A5A_1357, 1'b0, 1);
      get_word(32'h0000_1357, 4'h4, 1'b0);
      poll_chk(8'h03, 1'b1);
      set_cfg(txb_pkg::TXB_PACKET_L3, txb_pkg::TXB_W32, 1'b0, 1'b0);
      poll_chk(8'h23, 1'b1);
      poll_chk(8'h2C, 1'b0);
      // Address never selects here, so the last selection (port 3) stays
      i_txb_link_model.send(8'h07, 32'h1234_5678, 1'b0, 1);
      get_word(32'h1234_5678, 4'h3, 1'b0);
   endtask : t_pkt_l3

   task automatic t_overflow;
      set_cfg(txb_pkg::TXB_UTOPIA_L2, txb_pkg::TXB_W32, 1'b0, 1'b0);
      i_txb_link_model.send(8'h01, 32'h0000_0100, 1'b0, 11);
      i_txb_link_model.idle(2);
      check(overflow_seen, 1'b1, "overflow flag");
      for (int i = 0; i < 8; i++) begin
         get_word(32'h0000_0100 + i, 4'h1, 1'b0);
      end
      // The output stage may hold one more word; drain whatever is left
      repeat (60) begin
         @(posedge mclk);
         word_ready <= 1'b1;
      end
      @(posedge mclk);
      word_ready <= 1'b0;
      @(posedge mclk);
      check(word_valid, 1'b0, "drained");
   endtask : t_overflow

   initial begin
      mclk               = 1'b0;
      nrst               = 1'b0;
      word_ready         = 1'b0;
      cfg_bus_mode       = txb_pkg::TXB_UTOPIA_L2;
      cfg_bus_width      = txb_pkg::TXB_W32;
      cfg_parity_en      = 1'b0;
      cfg_parity_odd     = 1'b0;
      cfg_cell_threshold = 8'h00;
      port_cells_free    = {8'hFF, 88'h0};
      compares           = 0;
      miscompares        = 0;
      // The link domain also needs three of its own edges inside reset
      repeat (10) @(posedge mclk);
      repeat (3) @(posedge tx_sys_clock);
      @(posedge mclk);
      nrst <= 1'b1;
      i_txb_link_model.idle(5);
      t_width();
      t_parity();
      t_poll();
      t_pkt_l3();
      t_overflow();
      finish_test();
   end

endmodule : tb
